// ==== hw/fsg_pkg.sv ====
package fsg_pkg;

    // ----------------------------------------------------------------
    // Flash geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;          // Flash word address width
    localparam int FLASH_WORDS = 16384;  // Words in the whole array
    localparam int HALTING_SECTION_WORDS = 2048;    // Words in the halting section (top of array)

    // Boot section size per boot_size_fuses code, in words
    localparam logic [ADDR_W:0] BOOT_WORDS_3 = 15'h0100;
    localparam logic [ADDR_W:0] BOOT_WORDS_2 = 15'h0200;
    localparam logic [ADDR_W:0] BOOT_WORDS_1 = 15'h0400;
    localparam logic [ADDR_W:0] BOOT_WORDS_0 = 15'h0800;
    localparam int BOOT_WORDS_MAX = 2048;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] OFS_LOCK = 8'h00;   // Lock fields
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h04;   // Commands
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h08; // Block state

    // Lock register layout
    localparam int LOCK_APP_LSB = 0;
    localparam int LOCK_BOOT_LSB = 2;
    localparam logic [3:0] LOCK_RST = 4'hF;          // All unprogrammed

    // Control register bits
    localparam int CTRL_CHIP_ERASE = 0;
    localparam int CTRL_REENABLE = 1;

    // Status register bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_STALL = 1;
    localparam int STAT_OP = 2;
    localparam int STAT_IRQ_OFF = 3;
    localparam int STAT_FUSE_LSB = 4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_LOAD_READ = 3'h0,   // load_program_instruction read
        KIND_BUF_LOAD = 3'h1,    // Page buffer load by store instruction
        KIND_PAGE_ERASE = 3'h2,  // Page erase by store instruction
        KIND_PAGE_WRITE = 3'h3,  // Page write by store instruction
        KIND_REENABLE = 3'h4     // concurrent_section_reenable request
    } fsg_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONC = 2'h1,          // Programming the concurrent-read section
        ST_HALT = 2'h2           // Programming the halting section
    } fsg_state_t;

    typedef struct packed {
        logic valid;
        fsg_kind_t kind;
        logic [ADDR_W-1:0] addr;  // Target word address
        logic [ADDR_W-1:0] pc;    // Address of the executing instruction
    } fsg_cpu_req_t;

    typedef struct packed {
        logic done;
        logic granted;
    } fsg_cpu_resp_t;

    typedef struct packed {
        logic start;
        logic erase;
        logic [ADDR_W-1:0] addr;
    } fsg_flash_cmd_t;

    // ----------------------------------------------------------------
    // Lock field decoding, field is {upper, lower}
    // ----------------------------------------------------------------
    function automatic logic fsg_write_locked(input logic [1:0] field);
        return ~field[0];
    endfunction

    function automatic logic fsg_read_locked(input logic [1:0] field);
        return ~field[1];
    endfunction

    function automatic logic [ADDR_W:0] fsg_boot_words(input logic [1:0] fuses);
        logic [ADDR_W:0] w;
        w = BOOT_WORDS_0;
        case (fuses)
            2'h3: w = BOOT_WORDS_3;
            2'h2: w = BOOT_WORDS_2;
            2'h1: w = BOOT_WORDS_1;
            default: w = BOOT_WORDS_0;
        endcase
        return w;
    endfunction

endpackage

// ==== hw/fsg_section_map.sv ====
`timescale 1ns/1ps
`default_nettype none

// Classifies one word address into boot/application and halting/concurrent
module fsg_section_map #(
    parameter int FLASH_WORDS = fsg_pkg::FLASH_WORDS,
    parameter int HALTING_SECTION_WORDS = fsg_pkg::HALTING_SECTION_WORDS
) (
    input wire logic [fsg_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0] boot_size_fuses,
    output logic in_boot,
    output logic in_halt
);

    // ----------------------------------------------------------------
    // Section boundaries
    // ----------------------------------------------------------------
    localparam logic [fsg_pkg::ADDR_W:0] TOP = (fsg_pkg::ADDR_W+1)'(FLASH_WORDS);
    localparam logic [fsg_pkg::ADDR_W:0] HALT_BASE =
        (fsg_pkg::ADDR_W+1)'(FLASH_WORDS - HALTING_SECTION_WORDS);

    wire logic [fsg_pkg::ADDR_W:0] boot_base; // First boot word
    wire logic [fsg_pkg::ADDR_W:0] addr_x;    // Address widened for compare

    // Boot section sits at the top, sized by fuses
    assign boot_base = TOP - fsg_pkg::fsg_boot_words(boot_size_fuses); // [R1]
    assign addr_x = {1'b0, addr};
    assign in_boot = addr_x >= boot_base;
    assign in_halt = addr_x >= HALT_BASE;

endmodule
`default_nettype wire

// ==== hw/fsg_lock_check.sv ====
`timescale 1ns/1ps
`default_nettype none

// Decides whether a store or a load is allowed under the two lock fields
module fsg_lock_check (
    input wire logic exec_boot,
    input wire logic tgt_boot,
    input wire logic [1:0] app_lock,
    input wire logic [1:0] boot_lock,
    output logic store_ok,
    output logic read_ok
);

    // ----------------------------------------------------------------
    // Field selection
    // ----------------------------------------------------------------
    wire logic [1:0] tgt_field; // Field guarding the target section
    wire logic cross_read;      // Load crosses into the other section

    assign tgt_field = tgt_boot ? boot_lock : app_lock; // [R1]
    // Only boot code may program; any page incl. boot ones [R2] [R3]
    assign store_ok = exec_boot & ~fsg_pkg::fsg_write_locked(tgt_field); // [R15] [R18]
    // Reads within one's own section are never restricted
    assign cross_read = exec_boot ^ tgt_boot;
    assign read_ok = ~cross_read | ~fsg_pkg::fsg_read_locked(tgt_field); // [R16] [R19]

endmodule
`default_nettype wire

// ==== hw/fsg_guard.sv ====
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] Fuses size sections; each has own lock field
// [R2] Store from application section is ignored
// [R3] Boot store may target any page
// [R4] Concurrent-section op keeps CPU running
// [R5] Halting-section op stalls CPU, nothing readable
// [R6] Concurrent section unreadable during any programming
// [R7] Busy flag reads one while section blocked
// [R8] Software clears busy flag before concurrent reads
// [R9] Software never reads section being programmed
// [R10] Software disables or relocates interrupts meanwhile
// [R11] Boot section lies inside halting section
// [R12] Locks only programmed; chip erase restores
// [R13] Device-wide locks do not affect stores/loads
// [R14] Application mode 1 imposes no restriction
// [R15] Application modes 2,3 block stores
// [R16] Application modes 3,4 block boot reads
// [R17] Application modes 3,4 mask interrupts conditionally
// [R18] Boot modes 2,3 block stores
// [R19] Boot modes 3,4 block application reads
// [R20] Boot modes 3,4 mask interrupts conditionally
// [R21] Busy flag set on start, cleared by reenable/load
// [R22] Denied access changes nothing, raises nothing
module fsg_guard #(
    parameter int FLASH_WORDS = fsg_pkg::FLASH_WORDS,
    parameter int HALTING_SECTION_WORDS = fsg_pkg::HALTING_SECTION_WORDS
) (
    input wire logic mclk,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [fsg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fsg_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU side
    input wire fsg_pkg::fsg_cpu_req_t cpu_req,
    output fsg_pkg::fsg_cpu_resp_t cpu_resp,
    output logic cpu_stall,
    output logic irq_disable,
    // Fuses and vector placement
    input wire logic [1:0] boot_size_fuses,
    input wire logic vectors_in_boot,
    // Flash array
    output fsg_pkg::fsg_flash_cmd_t flash_cmd,
    input wire logic flash_done,
    output logic concurrent_blocked,
    output logic concurrent_section_busy_flag
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (HALTING_SECTION_WORDS < fsg_pkg::BOOT_WORDS_MAX || HALTING_SECTION_WORDS > FLASH_WORDS) // [R11]
    begin : g_bad_split
        $error("Halting section must hold the largest boot section");
    end
    if (FLASH_WORDS != (1 << fsg_pkg::ADDR_W))
    begin : g_bad_size
        $error("Flash size must match the address width");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fsg_pkg::fsg_state_t state_q, state_d; // Programming sequencer
    logic flag_q, flag_d;                  // Sticky flag feeding concurrent_section_busy_flag
    logic [3:0] lock_q, lock_d;            // {boot field, app field}
    logic stall_q, blocked_q, irq_off_q;   // Registered CPU-side levels
    fsg_pkg::fsg_cpu_resp_t resp_q;        // One-cycle answer
    fsg_pkg::fsg_flash_cmd_t cmd_q;        // Start pulse to the array

    // ----------------------------------------------------------------
    // Section and lock decoding
    // ----------------------------------------------------------------
    logic exec_boot, tgt_boot, tgt_halt;
    logic store_ok, read_ok;
    wire logic [1:0] app_lock = lock_q[fsg_pkg::LOCK_APP_LSB +: 2];
    wire logic [1:0] boot_lock = lock_q[fsg_pkg::LOCK_BOOT_LSB +: 2];

    // Where the executing instruction sits
    fsg_section_map #(
        .FLASH_WORDS(FLASH_WORDS),
        .HALTING_SECTION_WORDS(HALTING_SECTION_WORDS)
    ) u_map_exec (
        .addr(cpu_req.pc),
        .boot_size_fuses(boot_size_fuses),
        .in_boot(exec_boot),
        .in_halt()
    );

    // Where the access is aimed
    fsg_section_map #(
        .FLASH_WORDS(FLASH_WORDS),
        .HALTING_SECTION_WORDS(HALTING_SECTION_WORDS)
    ) u_map_tgt (
        .addr(cpu_req.addr),
        .boot_size_fuses(boot_size_fuses),
        .in_boot(tgt_boot),
        .in_halt(tgt_halt)
    );

    // Only the two boot lock fields matter; device-wide locks never reach here
    fsg_lock_check u_lock (                                  // [R13] [R14]
        .exec_boot(exec_boot),
        .tgt_boot(tgt_boot),
        .app_lock(app_lock),
        .boot_lock(boot_lock),
        .store_ok(store_ok),
        .read_ok(read_ok)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
    logic arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [fsg_pkg::AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;

    wire logic aw_hs = s_axi_awvalid & awready_q;
    wire logic w_hs = s_axi_wvalid & wready_q;
    wire logic b_hs = bvalid_q & s_axi_bready;
    wire logic ar_hs = s_axi_arvalid & arready_q;
    // Both halves held and no answer pending: perform the write
    wire logic wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    wire logic aw_full_d = (aw_full_q | aw_hs) & ~b_hs;
    wire logic w_full_d = (w_full_q | w_hs) & ~b_hs;
    wire logic rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
    wire logic [fsg_pkg::AXI_AW-1:0] wa = {awaddr_q[fsg_pkg::AXI_AW-1:2], 2'b00};
    wire logic [fsg_pkg::AXI_AW-1:0] ra = {s_axi_araddr[fsg_pkg::AXI_AW-1:2], 2'b00};
    wire logic wr_lock = wr_fire & wstrb0_q & (wa == fsg_pkg::OFS_LOCK);
    wire logic wr_ctrl = wr_fire & wstrb0_q & (wa == fsg_pkg::OFS_CTRL);
    wire logic wr_mapped = (wa == fsg_pkg::OFS_LOCK) | (wa == fsg_pkg::OFS_CTRL)
        | (wa == fsg_pkg::OFS_STATUS);
    wire logic chip_erase = wr_ctrl & wdata_q[fsg_pkg::CTRL_CHIP_ERASE];
    wire logic axi_reen = wr_ctrl & wdata_q[fsg_pkg::CTRL_REENABLE];

    // Status word shows the block's own state
    wire logic [31:0] status_word = {26'h0, boot_size_fuses, irq_off_q,
        (state_q != fsg_pkg::ST_IDLE), stall_q, blocked_q}; // [R7]
    wire logic rd_mapped = (ra == fsg_pkg::OFS_LOCK) | (ra == fsg_pkg::OFS_CTRL)
        | (ra == fsg_pkg::OFS_STATUS);
    wire logic [31:0] rd_word = (ra == fsg_pkg::OFS_LOCK) ? {28'h0, lock_q}
        : (ra == fsg_pkg::OFS_STATUS) ? status_word : 32'h0;

    // Write channel: accept address and data in either order
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= fsg_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            if (aw_hs)
                awaddr_q <= s_axi_awaddr;
            if (w_hs)
            begin
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            // Response once both halves are in; unmapped gives SLVERR
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? fsg_pkg::RESP_OKAY : fsg_pkg::RESP_SLVERR;
            end
            else if (b_hs)
                bvalid_q <= 1'b0;
        end
    end

    // Read channel: one-cycle answer, held until rready
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= fsg_pkg::RESP_OKAY;
        end
        else
        begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_hs)
            begin
                rdata_q <= rd_word;
                rresp_q <= rd_mapped ? fsg_pkg::RESP_OKAY : fsg_pkg::RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Request decoding
    // ----------------------------------------------------------------
    wire logic idle = (state_q == fsg_pkg::ST_IDLE);
    wire logic is_prog = cpu_req.valid & ((cpu_req.kind == fsg_pkg::KIND_PAGE_ERASE)
        | (cpu_req.kind == fsg_pkg::KIND_PAGE_WRITE));
    // Application-side store attempts fall out through store_ok
    wire logic prog_start = is_prog & store_ok & idle;               // [R2] [R22]
    wire logic buf_load = cpu_req.valid & (cpu_req.kind == fsg_pkg::KIND_BUF_LOAD)
        & exec_boot & idle;                                          // [R2]
    // Reenable only honoured once the array is no longer busy
    wire logic cpu_reen = cpu_req.valid & (cpu_req.kind == fsg_pkg::KIND_REENABLE)
        & exec_boot & idle;
    wire logic reen = cpu_reen | (axi_reen & idle);
    // Halting section stays readable only during a concurrent-section op
    wire logic readable = idle ? (~flag_q | tgt_halt)
        : (state_q == fsg_pkg::ST_CONC) & tgt_halt;                  // [R4] [R6]
    wire logic read_grant = cpu_req.valid & (cpu_req.kind == fsg_pkg::KIND_LOAD_READ)
        & read_ok & readable;                                        // [R16] [R19]
    wire logic granted_d = prog_start | buf_load | cpu_reen | read_grant;

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            fsg_pkg::ST_IDLE:
                if (prog_start)
                    state_d = tgt_halt ? fsg_pkg::ST_HALT : fsg_pkg::ST_CONC; // [R4] [R5]
            fsg_pkg::ST_CONC, fsg_pkg::ST_HALT:
                if (flash_done)
                    state_d = fsg_pkg::ST_IDLE;
            default:
                state_d = fsg_pkg::ST_IDLE;
        endcase
    end

    // Busy flag: concurrent-section start sets, reenable or buffer load clears, set first
    assign flag_d = (prog_start & ~tgt_halt) ? 1'b1
        : (buf_load | reen) ? 1'b0 : flag_q;                         // [R21]

    // Locks only ever move from 1 to 0; chip erase restores them
    assign lock_d = chip_erase ? fsg_pkg::LOCK_RST
        : wr_lock ? (lock_q & wdata_q[3:0]) : lock_q;                // [R12]

    // Interrupt masking when vectors sit in the other section
    wire logic irq_off_d =
        (fsg_pkg::fsg_read_locked(app_lock) & vectors_in_boot & ~exec_boot)    // [R17]
        | (fsg_pkg::fsg_read_locked(boot_lock) & ~vectors_in_boot & exec_boot); // [R20]

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Sequencer, flag and locks
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= fsg_pkg::ST_IDLE;
            flag_q <= 1'b0;
            lock_q <= fsg_pkg::LOCK_RST;
        end
        else
        begin
            state_q <= state_d;
            flag_q <= flag_d;
            lock_q <= lock_d;
        end
    end

    // CPU-facing outputs, all registered; stall and blocked from next-state values
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            stall_q <= 1'b0;
            blocked_q <= 1'b0;
            irq_off_q <= 1'b0;
            resp_q <= '0;
            cmd_q <= '0;
        end
        else
        begin
            stall_q <= (state_d == fsg_pkg::ST_HALT);                      // [R5]
            blocked_q <= (state_d != fsg_pkg::ST_IDLE) | flag_d;           // [R6] [R7]
            irq_off_q <= irq_off_d;
            resp_q <= '{done: cpu_req.valid, granted: granted_d};          // [R22]
            cmd_q <= '{start: prog_start,
                erase: (cpu_req.kind == fsg_pkg::KIND_PAGE_ERASE), addr: cpu_req.addr};
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign cpu_resp = resp_q;
    assign cpu_stall = stall_q;
    assign irq_disable = irq_off_q;
    assign flash_cmd = cmd_q;
    assign concurrent_blocked = blocked_q;
    assign concurrent_section_busy_flag = blocked_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_APP_STORE_IGNORED: assert property ( // [R2]
        is_prog && !exec_boot |=> !cpu_resp.granted && !flash_cmd.start)
        else $error("Store from application section was acted on");
    AST_HALT_STALL: assert property ( // [R5]
        prog_start && tgt_halt |=> cpu_stall && flash_cmd.start)
        else $error("Halting-section op did not stall the CPU");
    AST_STALL_HOLD: assert property ( // [R5]
        cpu_stall && !flash_done |=> cpu_stall)
        else $error("Stall dropped before the operation ended");
    AST_CONC_RUNS: assert property ( // [R4]
        prog_start && !tgt_halt |=> !cpu_stall && concurrent_blocked [*2])
        else $error("Concurrent-section op stalled or left section open");
    AST_BLOCK_DURING_OP: assert property ( // [R6]
        !idle && read_grant |-> tgt_halt && concurrent_blocked)
        else $error("Concurrent section readable during programming");
    AST_FLAG_REPORT: assert property ( // [R7]
        !concurrent_section_busy_flag |-> readable && !flag_q)
        else $error("Busy flag not reported while section blocked");
    AST_APP_WRITE_LOCK: assert property ( // [R15]
        is_prog && !tgt_boot && !app_lock[0] |=> !flash_cmd.start)
        else $error("Store reached a write-locked application page");
    AST_BOOT_READ_LOCK: assert property ( // [R19]
        cpu_req.valid && cpu_req.kind == fsg_pkg::KIND_LOAD_READ && !exec_boot
        && tgt_boot && !boot_lock[1] |=> cpu_resp.done && !cpu_resp.granted)
        else $error("Application read of a read-locked boot section");
    AST_LOCK_ONLY_PROGRAMS: assert property ( // [R12]
        !chip_erase |=> (lock_q & ~$past(lock_q)) == 4'h0)
        else $error("Lock bit returned to unprogrammed without chip erase");
    AST_BUF_LOAD_CLEARS: assert property ( // [R21]
        buf_load |=> !concurrent_section_busy_flag)
        else $error("Buffer load did not clear the busy flag");

endmodule
`default_nettype wire

// ==== tb/fsg_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Flash array stand-in: ends each started op after a random delay
// ----------------------------------------------------------------
module fsg_flash_model (
    input wire logic mclk,
    input wire fsg_pkg::fsg_flash_cmd_t flash_cmd,
    output logic flash_done
);
    // One op at a time, as the array itself allows
    initial
    begin
        flash_done = 1'b0;
        forever
        begin
            @(posedge mclk);
            if (flash_cmd.start === 1'b1)
            begin
                // Long enough that probes land mid-operation
                repeat (6 + $urandom % 8) @(posedge mclk);
                flash_done <= 1'b1;
                @(posedge mclk);
                flash_done <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb/flash_section_access_guard_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module flash_section_access_guard_test;
    // ----------------------------------------------------------------
    // Bench signals
    // ----------------------------------------------------------------
    logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, vib, stall, done, blk, busy, g, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] rresp, rr, fuses, bresp;
    logic [13:0] bw, ap, bp;
    fsg_pkg::fsg_cpu_req_t req;
    fsg_pkg::fsg_cpu_resp_t resp;
    fsg_pkg::fsg_flash_cmd_t cmd;
    int n_fail, checks;

    fsg_guard u_fsg_guard (
        .mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_req(req), .cpu_resp(resp),
        .cpu_stall(stall), .irq_disable(irq), .boot_size_fuses(fuses), .vectors_in_boot(vib),
        .flash_cmd(cmd), .flash_done(done), .concurrent_blocked(blk),
        .concurrent_section_busy_flag(busy));
    fsg_flash_model u_fsg_flash_model (.mclk(mclk), .flash_cmd(cmd), .flash_done(done));

    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic c, input string m);
        checks++;
        if (c !== 1'b1)
        begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask

    // Master holds each channel until its own ready
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk(bresp === {a > 8'h08, 1'b0}, "bresp");
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask

    // One-cycle CPU request; answer sampled after the taking edge settles
    task automatic drv(input logic [2:0] k, input logic [13:0] a, input logic [13:0] p);
        @(posedge mclk);
        req <= {1'b1, k, a, p};
        @(posedge mclk);
        req.valid <= 1'b0;
        #1 g = resp.granted;
        chk(resp.done === 1'b1, "no answer");
    endtask

    // Granted erase/write is run to the end and the section re-enabled
    task automatic op(input logic [2:0] k, input logic [13:0] a, input logic [13:0] p,
                      input logic e);
        drv(k, a, p);
        chk(g === e, "grant");
        if (g && k[1])
        begin
            do @(posedge mclk); while (done !== 1'b1);
            drv(3'h4, 14'h3FFF, 14'h3FFF);
        end
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        #200000;
        n_fail++;
        results();
    end

    initial
    begin
        void'($urandom(32'hA80F4083));
        {resetn, req, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, fuses, vib} = '0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        axr(8'h00, rd, rr);
        chk(rd[3:0] === 4'hF, "lock reset");
        axr(8'h0C, rd, rr);
        chk(rr === fsg_pkg::RESP_SLVERR, "unmapped");
        axw(8'h0C, 32'h0);
        op(3'h3, 14'h0100, 14'h0000, 1'b0);
        drv(3'h3, 14'h0100, 14'h3FFF);
        chk(g && blk === 1'b1 && stall === 1'b0 && cmd === {2'h2, 14'h0100}, "conc op");
        op(3'h0, 14'h3900, 14'h3FFF, 1'b1);
        op(3'h0, 14'h0200, 14'h3FFF, 1'b0);
        do @(posedge mclk); while (done !== 1'b1);
        #1 chk(busy === 1'b1, "flag dropped");
        axr(8'h08, rd, rr);
        chk(rd[5:0] === 6'h01, "status");
        op(3'h4, 14'h0000, 14'h3FFF, 1'b1);
        @(posedge mclk);
        #1 chk(blk === 1'b0, "reenable");
        drv(3'h2, 14'h0300, 14'h3FFF);
        do @(posedge mclk); while (done !== 1'b1);
        axw(8'h04, 32'h2);
        #1 chk(blk === 1'b0, "ctrl reenable");
        drv(3'h2, 14'h0300, 14'h3FFF);
        do @(posedge mclk); while (done !== 1'b1);
        drv(3'h1, 14'h0000, 14'h3FFF);
        @(posedge mclk);
        #1 chk(blk === 1'b0, "buffer load");
        drv(3'h2, 14'h3A00, 14'h3FFF);
        chk(stall === 1'b1 && blk === 1'b1 && cmd === {2'h3, 14'h3A00}, "halting op");
        op(3'h0, 14'h3900, 14'h3FFF, 1'b0);
        do @(posedge mclk); while (done !== 1'b1);
        @(posedge mclk);
        #1 chk(stall === 1'b0, "stall end");
        // Every lock value under random fuses
        for (int i = 0; i < 16; i++)
        begin
            fuses <= 2'($urandom);
            vib <= 1'($urandom);
            axw(8'h04, 32'h1);
            axw(8'h00, 32'(i));
            axr(8'h00, rd, rr);
            chk(rd[3:0] === 4'(i), "lock");
            bw = 14'h100 << (3 - fuses);
            ap = 14'($urandom % (32'd16384 - bw));
            bp = 14'(32'd16384 - bw + $urandom % bw);
            op(3'h3, ap, 14'h3FFF, i[0]);
            op(3'h3, bp, 14'h3FFF, i[2]);
            op(3'h0, ap, 14'h3FFF, i[1]);
            chk(irq === (!i[3] && !vib), "irq boot");
            op(3'h0, bp, 14'h0000, i[3]);
            chk(irq === (!i[1] && vib), "irq app");
        end
        results();
    end
endmodule

`default_nettype wire
